// *** hw/vesm_pkg.sv ***
package vesm_pkg;
   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ        = 10_000_000;
   localparam int DEBOUNCE_MS   = 10;
   localparam int DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int H_MIN_NS      = -7000;
   localparam int H_MAX_NS      = 12000;
   localparam int H_STEP_NS     = 2;
   localparam int H_MIN_STEPS   = H_MIN_NS / H_STEP_NS;
   localparam int H_MAX_STEPS   = H_MAX_NS / H_STEP_NS;
   localparam int SC_HALF_DDEG  = 1800;     // 180 degrees, in tenths
   localparam int SC_STEP_DDEG  = 3;        // 0.3 degree, in tenths
   localparam int SC_MAX_STEPS  = SC_HALF_DDEG / SC_STEP_DDEG;
   localparam int FREE_DELAY_NS = 7000;     // encoder delay, free-run
   localparam int DAC_RATE_HZ   = 27_000_000;
   localparam int VID_W         = 10;
   localparam int JBUF_DEPTH    = 16;

   // ------------------------------------------------------------
   // menu entries, display characters, ranges, defaults
   // ------------------------------------------------------------
   localparam int NENT = 12;
   localparam logic [3:0] ENT_SC = 4'h0, ENT_HP = 4'h1, ENT_CFG = 4'h8;
   localparam logic [3:0] ENT_GEN = 4'h9, ENT_LINE = 4'hA, ENT_PROG = 4'hB;
   localparam logic [3:0] ENT_LAST = 4'hB;
   localparam logic [NENT-1:0][7:0] ENT_CHAR = {8'h50, 8'h4C, 8'h47,
      8'h43, 8'h54, 8'h48, 8'h45, 8'h55, 8'h55, 8'h59, 8'h48, 8'h53};
   localparam logic [NENT-1:0][3:0] ENT_MAX = {4'h0, 4'h6, 4'h1, 4'h2,
      4'h2, 4'h9, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
   localparam logic [NENT-1:0][3:0] ENT_MIN = {4'h0, 4'h4, 4'h0, 4'h0,
      4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
   localparam logic [NENT-1:0][3:0] ENT_DEF = {4'h0, 4'h6, 4'h1, 4'h0,
      4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8};
   localparam logic [3:0] LINE_PAL = 4'h6, LINE_NTSC = 4'h5;
   localparam logic [3:0] CFG_ENC = 4'h0, CFG_RAMP = 4'h1, CFG_BARS = 4'h2;
   localparam logic [7:0] CH_E = 8'h45, CH_L = 8'h4C, CH_B = 8'h62;
   localparam logic [7:0] CH_S = 8'h53, CH_0 = 8'h30, CH_A = 8'h37;
   localparam logic [1:0] STORE_LAST = 2'h3;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_HPHASE = 8'h04;
   localparam logic [7:0] REG_SCPHASE = 8'h08;
   localparam logic [7:0] REG_LIVE   = 8'h0C;
   localparam logic [7:0] REG_SAVED  = 8'h10;
   localparam logic [1:0] RESP_OK = 2'h0, RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      VESM_BROWSE = 2'b00,
      VESM_EDIT   = 2'b01,
      VESM_STORE  = 2'b11
   } vesm_state_t;

   typedef struct packed {
      logic plus;
      logic minus;
      logic sel;
   } vesm_btn_t;

   typedef struct packed {
      logic               genlock;      // 1: reference, 0: input data
      logic [3:0]         line_mode;
      logic [1:0]         vbi_mode;
      logic signed [13:0] h_steps;      // 2 ns units
      logic signed [10:0] sc_steps;     // 0.3 degree units
   } vesm_sync_t;
endpackage

// *** hw/vesm_top.sv ***
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// line jitter buffer fifo
// ------------------------------------------------------------
module vesm_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // drain side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q, rd_q;
   logic [AW:0]      cnt_q;
   logic             push, pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_q];
   assign out_valid = (cnt_q != '0);
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));

   // storage has no reset, pointers do
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// Summary of operation
// - green: plus/minus step menu entry
// - red: plus/minus change selected value
// - select toggles browse/edit, LED follows
// - five defaults follow line standard, 0-F
// - genlock default 1, 0 follows input
// - teletext default 0; 1,2 pass VBI
// - config default E; L ramp, b bars
// - P, select, three plus: 1,2,3,S stores
// - H phase -7..+12 us, 2 ns steps
// - SC phase +/-180 deg, 0.3 deg steps
// - free-run timing follows input data
// - one-line buffer absorbs input jitter
// - ten input bits all significant
// - 10-bit samples to the converters
module vesm_top #(
   parameter int          DEBOUNCE_CYC = vesm_pkg::DEBOUNCE_CYC,
   parameter int          VID_W        = vesm_pkg::VID_W,
   parameter int          JBUF_DEPTH   = vesm_pkg::JBUF_DEPTH,
   parameter logic [19:0] DEF_PAL      = 20'h88888,
   parameter logic [19:0] DEF_NTSC     = 20'h88888,
   parameter logic [19:0] DEF_JAPAN    = 20'h88888
) (
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   // front panel
   input  wire vesm_pkg::vesm_btn_t  btn,
   output logic                      led_red,
   output logic                      led_green,
   output logic [7:0]                disp_char,
   // sync settings and store event
   output vesm_pkg::vesm_sync_t      sync_cfg,
   output logic                      store_pulse,
   // input video
   input  wire logic [VID_W-1:0]     vin_data,
   input  wire logic                 vin_valid,
   output logic                      vin_ready,
   // converter samples
   output logic [VID_W-1:0]          dac_data,
   output logic                      dac_valid,
   input  wire logic                 dac_ready,
   // axi4-lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);
   localparam int DBW = $clog2(DEBOUNCE_CYC + 1);

   // ------------------------------------------------------------
   // button debounce
   // ------------------------------------------------------------
   logic [2:0] raw, stable_q, press_q;
   assign raw = {btn.plus, btn.minus, btn.sel};

   // a level must hold for the full window before it is believed,
   // so contact bounce never yields a second press
   for (genvar i = 0; i < 3; i++) begin : g_deb
      logic [DBW-1:0] cnt_q;
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            cnt_q       <= '0;
            stable_q[i] <= 1'b0;
            press_q[i]  <= 1'b0;
         end else begin
            press_q[i] <= 1'b0;
            if (raw[i] == stable_q[i]) begin
               cnt_q <= '0;
            end else if (cnt_q == DBW'(DEBOUNCE_CYC - 1)) begin
               cnt_q       <= '0;
               stable_q[i] <= raw[i];
               press_q[i]  <= raw[i];
            end else begin
               cnt_q <= cnt_q + DBW'(1);
            end
         end
      end
   end

   logic ev_plus, ev_minus, ev_sel;
   assign ev_plus  = press_q[2];
   assign ev_minus = press_q[1];
   assign ev_sel   = press_q[0];

   // ------------------------------------------------------------
   // menu state machine and parameter values
   // ------------------------------------------------------------
   vesm_pkg::vesm_state_t         state_q;
   logic [3:0]                    ent_q;
   logic [1:0]                    store_cnt_q;
   logic                          store_done_q;
   logic [vesm_pkg::NENT-1:0][3:0] val_q, saved_q;
   logic [3:0]                    cur, cur_max, cur_min;
   logic [19:0]                   std_def;

   assign cur     = val_q[ent_q];
   assign cur_max = vesm_pkg::ENT_MAX[ent_q];
   assign cur_min = vesm_pkg::ENT_MIN[ent_q];

   // standard-dependent defaults for the five picture parameters
   always_comb begin
      case (val_q[vesm_pkg::ENT_LINE])
         vesm_pkg::LINE_PAL:  std_def = DEF_PAL;
         vesm_pkg::LINE_NTSC: std_def = DEF_NTSC;
         default:             std_def = DEF_JAPAN;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q      <= vesm_pkg::VESM_BROWSE;
         ent_q        <= '0;
         store_cnt_q  <= '0;
         store_done_q <= 1'b0;
      end else begin
         case (state_q)
            vesm_pkg::VESM_BROWSE: begin
               if (ev_sel) begin
                  state_q <= (ent_q == vesm_pkg::ENT_PROG) ?
                             vesm_pkg::VESM_STORE : vesm_pkg::VESM_EDIT;
                  store_cnt_q  <= 2'h1;
                  store_done_q <= 1'b0;
               end else if (ev_plus) begin
                  ent_q <= (ent_q == vesm_pkg::ENT_LAST) ?
                           '0 : ent_q + 4'h1;
               end else if (ev_minus) begin
                  ent_q <= (ent_q == '0) ?
                           vesm_pkg::ENT_LAST : ent_q - 4'h1;
               end
            end
            vesm_pkg::VESM_EDIT: begin
               if (ev_sel) begin
                  state_q <= vesm_pkg::VESM_BROWSE;
               end
            end
            vesm_pkg::VESM_STORE: begin
               if (ev_sel) begin
                  state_q <= vesm_pkg::VESM_BROWSE;
               end else if (ev_plus && !store_done_q) begin
                  if (store_cnt_q == vesm_pkg::STORE_LAST) begin
                     store_done_q <= 1'b1;
                  end else begin
                     store_cnt_q <= store_cnt_q + 2'h1;
                  end
               end
            end
            default: state_q <= vesm_pkg::VESM_BROWSE;
         endcase
      end
   end

   // value edits; limits hold rather than wrap around
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         val_q <= vesm_pkg::ENT_DEF;
      end else if (state_q == vesm_pkg::VESM_EDIT && !ev_sel) begin
         if (ev_plus && cur < cur_max) begin
            val_q[ent_q] <= cur + 4'h1;
         end else if (ev_minus && cur > cur_min) begin
            val_q[ent_q] <= cur - 4'h1;
         end
      end else if (state_q == vesm_pkg::VESM_EDIT &&
                   ent_q == vesm_pkg::ENT_LINE) begin
         // leaving line mode reloads the standard's picture defaults
         for (int k = 0; k < 5; k++) begin
            val_q[k] <= std_def[4*k +: 4];
         end
      end
   end

   // saved image, written once per completed store sequence
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         saved_q     <= vesm_pkg::ENT_DEF;
         store_pulse <= 1'b0;
      end else begin
         store_pulse <= 1'b0;
         if (state_q == vesm_pkg::VESM_STORE && ev_plus && !ev_sel &&
             !store_done_q && store_cnt_q == vesm_pkg::STORE_LAST) begin
            saved_q     <= val_q;
            store_pulse <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // led and display
   // ------------------------------------------------------------
   logic [7:0] disp_d;
   always_comb begin
      disp_d = vesm_pkg::ENT_CHAR[ent_q];
      if (state_q == vesm_pkg::VESM_STORE) begin
         disp_d = store_done_q ? vesm_pkg::CH_S :
                  vesm_pkg::CH_0 + {6'h0, store_cnt_q};
      end else if (state_q == vesm_pkg::VESM_EDIT) begin
         if (ent_q == vesm_pkg::ENT_CFG) begin
            disp_d = (cur == vesm_pkg::CFG_RAMP) ? vesm_pkg::CH_L :
                     (cur == vesm_pkg::CFG_BARS) ? vesm_pkg::CH_B :
                     vesm_pkg::CH_E;
         end else begin
            disp_d = (cur > 4'h9) ? vesm_pkg::CH_A + {4'h0, cur} :
                     vesm_pkg::CH_0 + {4'h0, cur};
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         led_red   <= 1'b0;
         led_green <= 1'b1;
         disp_char <= vesm_pkg::ENT_CHAR[0];
      end else begin
         led_red   <= (state_q != vesm_pkg::VESM_BROWSE);
         led_green <= (state_q == vesm_pkg::VESM_BROWSE);
         disp_char <= disp_d;
      end
   end

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   logic               aw_q, w_q;
   logic [7:0]         awaddr_q;
   logic [31:0]        wdata_q;
   logic signed [13:0] h_reg_q;
   logic signed [10:0] sc_reg_q;
   logic signed [31:0] wd_s;
   assign wd_s = $signed(wdata_q);

   // address and data are latched independently, in either order
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aw_q          <= 1'b0;
         w_q           <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= vesm_pkg::RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q          <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q          <= 1'b1;
            wdata_q      <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (aw_q && w_q && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == vesm_pkg::REG_HPHASE ||
                             awaddr_q == vesm_pkg::REG_SCPHASE) ?
                            vesm_pkg::RESP_OK : vesm_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_q          <= 1'b0;
            w_q           <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // fine phase registers; writes outside the range are clamped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         h_reg_q  <= '0;
         sc_reg_q <= '0;
      end else if (aw_q && w_q && !s_axi_bvalid && s_axi_wstrb != 4'h0) begin
         if (awaddr_q == vesm_pkg::REG_HPHASE) begin
            h_reg_q <= (wd_s < vesm_pkg::H_MIN_STEPS) ?
                       14'(vesm_pkg::H_MIN_STEPS) :
                       (wd_s > vesm_pkg::H_MAX_STEPS) ?
                       14'(vesm_pkg::H_MAX_STEPS) : wd_s[13:0];
         end
         if (awaddr_q == vesm_pkg::REG_SCPHASE) begin
            sc_reg_q <= (wd_s < -vesm_pkg::SC_MAX_STEPS) ?
                        11'(-vesm_pkg::SC_MAX_STEPS) :
                        (wd_s > vesm_pkg::SC_MAX_STEPS) ?
                        11'(vesm_pkg::SC_MAX_STEPS) : wd_s[10:0];
         end
      end
   end

   // reads answer one cycle after the address is taken
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= vesm_pkg::RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= vesm_pkg::RESP_OK;
         case (s_axi_araddr)
            vesm_pkg::REG_STATUS:  s_axi_rdata <= {21'h0, store_done_q,
               store_cnt_q, state_q, ent_q, led_red, led_green};
            vesm_pkg::REG_HPHASE:  s_axi_rdata <= 32'(h_reg_q);
            vesm_pkg::REG_SCPHASE: s_axi_rdata <= 32'(sc_reg_q);
            vesm_pkg::REG_LIVE:    s_axi_rdata <= val_q[7:0];
            vesm_pkg::REG_SAVED:   s_axi_rdata <= saved_q[7:0];
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= vesm_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // sync settings
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync_cfg <= '{genlock: 1'b1, line_mode: vesm_pkg::LINE_PAL,
                       vbi_mode: 2'h0, h_steps: '0, sc_steps: '0};
      end else begin
         // free-run follows the input data, genlock the reference
         sync_cfg.genlock   <= val_q[vesm_pkg::ENT_GEN][0];
         sync_cfg.line_mode <= val_q[vesm_pkg::ENT_LINE];
         sync_cfg.vbi_mode  <= val_q[7][1:0];
         sync_cfg.h_steps   <= val_q[vesm_pkg::ENT_GEN][0] ? h_reg_q : '0;
         sync_cfg.sc_steps  <= val_q[vesm_pkg::ENT_GEN][0] ? sc_reg_q : '0;
      end
   end

   // ------------------------------------------------------------
   // video path: jitter buffer, source select, converter output
   // ------------------------------------------------------------
   logic [VID_W-1:0] jb_data, gen_q, src;
   logic             jb_valid, jb_ready, take;
   logic [3:0]       cfg;
   assign cfg = val_q[vesm_pkg::ENT_CFG];

   vesm_fifo #(.WIDTH(VID_W), .DEPTH(JBUF_DEPTH)) line_jitter_buffer (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_data   (vin_data),
      .in_valid  (vin_valid),
      .in_ready  (vin_ready),
      .out_data  (jb_data),
      .out_valid (jb_valid),
      .out_ready (jb_ready)
   );

   // test patterns run freely; the buffer only drains in encoder mode
   assign take     = !dac_valid || dac_ready;
   assign jb_ready = take && cfg == vesm_pkg::CFG_ENC;
   assign src      = (cfg == vesm_pkg::CFG_ENC) ? jb_data : gen_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gen_q <= '0;
      end else if (take && cfg != vesm_pkg::CFG_ENC) begin
         gen_q <= (cfg == vesm_pkg::CFG_BARS) ?
                  {gen_q[VID_W-1 -: 3] + 3'h1, {(VID_W-3){1'b0}}} :
                  gen_q + VID_W'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dac_valid <= 1'b0;
         dac_data  <= '0;
      end else if (take) begin
         dac_valid <= (cfg != vesm_pkg::CFG_ENC) || jb_valid;
         dac_data  <= src;
      end
   end
endmodule

`default_nettype wire

// *** testbench/vesm_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module vesm_chk #(
   parameter int VID_W = 10
) (
   // clock and reset
   input wire logic                 sys_clk,
   input wire logic                 rst,
   // panel and settings
   input wire logic                 led_red,
   input wire logic                 led_green,
   input wire logic                 store_pulse,
   input wire vesm_pkg::vesm_sync_t sync_cfg,
   // converter side
   input wire logic [VID_W-1:0]     dac_data,
   input wire logic                 dac_valid,
   input wire logic                 dac_ready,
   // bus answers
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // a stalled answer must not move
   sequence dac_stall; dac_valid && !dac_ready; endsequence
   sequence b_stall; s_axi_bvalid && !s_axi_bready; endsequence
   sequence r_stall; s_axi_rvalid && !s_axi_rready; endsequence
   led_one_hot_a: assert property (led_red != led_green)
      else $error("led clash");
   store_single_a: assert property (store_pulse |=> !store_pulse)
      else $error("store long");
   dac_hold_a: assert property (dac_stall |=> dac_valid && $stable(dac_data))
      else $error("dac moved");
   bresp_hold_a: assert property (b_stall |=> s_axi_bvalid)
      else $error("b dropped");
   rresp_hold_a: assert property (r_stall |=> s_axi_rvalid)
      else $error("r dropped");
   h_range_a: assert property (sync_cfg.h_steps >= vesm_pkg::H_MIN_STEPS &&
      sync_cfg.h_steps <= vesm_pkg::H_MAX_STEPS) else $error("h range");
   sc_range_a: assert property (sync_cfg.sc_steps <= vesm_pkg::SC_MAX_STEPS &&
      sync_cfg.sc_steps >= -vesm_pkg::SC_MAX_STEPS) else $error("sc range");
   free_zero_a: assert property (!sync_cfg.genlock |->
      sync_cfg.h_steps == 0 && sync_cfg.sc_steps == 0) else $error("free phase");
   line_code_a: assert property (sync_cfg.line_mode inside {4'h4, 4'h5, 4'h6})
      else $error("line code");
   vbi_code_a: assert property (sync_cfg.vbi_mode <= 2'h2)
      else $error("vbi code");
endmodule
`default_nettype wire

// *** testbench/vesm_panel.sv ***
`timescale 1ns/1ps
`default_nettype none
module vesm_panel #(
   parameter int HOLD = 8
) (
   // clock
   input wire logic                sys_clk,
   // buttons
   output var vesm_pkg::vesm_btn_t btn
);
   // all buttons up at power-on
   initial btn = '0;
   // k: 0 plus, 1 minus, 2 select
   task automatic press(input int k);
      @(posedge sys_clk);
      btn <= 3'b100 >> k;
      repeat (HOLD) @(posedge sys_clk);
      btn <= '0;
      repeat (HOLD) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// *** testbench/vesm_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
   $display("wrong value %s exp %0h seen %0h", n, e, s); end end
module vesm_top_bench;
   logic sys_clk, rst, vin_valid, dac_ready, vin_ready, dac_valid;
   logic led_red, led_green, store_pulse, rb;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr, disp_char;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, live;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [9:0] vin_data, dac_data;
   vesm_pkg::vesm_btn_t btn;
   vesm_pkg::vesm_sync_t sync_cfg;
   int n_fail = 0, n_tests = 0, n_store = 0, n, j, i;
   // short debounce keeps each press to a few cycles
   vesm_top #(.DEBOUNCE_CYC(4)) i_vesm_top (.*, .s_axi_wstrb(4'hF));
   vesm_panel i_vesm_panel (.sys_clk, .btn);
   // clock and store pulse counter
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (store_pulse === 1'b1) n_store++;
   task results;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task tmo(input logic late);
      if (late) begin
         n_fail++;
         results;
      end
   endtask
   // requests hold until taken at a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      rb = 1'b0;
      for (i = 0; i < 50 && !rb; i++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         {rb, r} = {s_axi_bvalid, s_axi_bresp};
      end
      s_axi_bready <= 1'b0;
      tmo(!rb);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      rb = 1'b0;
      for (i = 0; i < 50 && !rb; i++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         {rb, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      end
      s_axi_rready <= 1'b0;
      tmo(!rb);
   endtask
   task key(input int k);
      i_vesm_panel.press(k);
      @(negedge sys_clk);
   endtask
   task t_reset;
      `CK("genlock", 1'b1, sync_cfg.genlock)
      `CK("line", vesm_pkg::LINE_PAL, sync_cfg.line_mode)
      `CK("vbi", 2'h0, sync_cfg.vbi_mode)
      rd(vesm_pkg::REG_LIVE);
      live = d;
      `CK("live", 32'h00088888, live)
   endtask
   task t_cfg;
      key(0);
      `CK("disp", 8'h48, disp_char)
      key(1);
      `CK("disp", vesm_pkg::CH_S, disp_char)
      repeat (8) key(0);
      key(2);
      `CK("red", 1'b1, led_red)
      `CK("cfg", vesm_pkg::CH_E, disp_char)
      key(0);
      `CK("cfg", vesm_pkg::CH_L, disp_char)
      key(0);
      key(0);
      `CK("cfg", vesm_pkg::CH_B, disp_char)
      key(1);
      key(1);
      `CK("cfg", vesm_pkg::CH_E, disp_char)
      key(2);
      `CK("green", 1'b1, led_green)
   endtask
   task t_axi;
      wr(vesm_pkg::REG_HPHASE, 32'h00001B58);
      rd(vesm_pkg::REG_HPHASE);
      `CK("hph", 14'h1770, d[13:0])
      wr(vesm_pkg::REG_SCPHASE, 32'hFFFFFD44);
      @(negedge sys_clk);
      `CK("scph", 11'h5A8, sync_cfg.sc_steps)
      wr(vesm_pkg::REG_STATUS, 32'h0);
      `CK("bresp", vesm_pkg::RESP_SLVERR, r)
      rd(8'h40);
      `CK("rresp", vesm_pkg::RESP_SLVERR, r)
   endtask
   task t_gen;
      key(0);
      key(2);
      `CK("gen", 8'h31, disp_char)
      key(1);
      key(1);
      `CK("gen", 1'b0, sync_cfg.genlock)
      `CK("hph", 14'h0, sync_cfg.h_steps)
      key(0);
      key(2);
      `CK("gen", 1'b1, sync_cfg.genlock)
   endtask
   task t_store;
      key(0);
      key(0);
      `CK("disp", 8'h50, disp_char)
      key(2);
      for (j = 1; j < 4; j++) begin
         `CK("store", vesm_pkg::CH_0 + 8'(j), disp_char)
         key(0);
      end
      `CK("store", vesm_pkg::CH_S, disp_char)
      `CK("pulses", 1, n_store)
      rd(vesm_pkg::REG_SAVED);
      `CK("saved", live, d)
      key(2);
   endtask
   // far side stalls while the buffer fills, then drains
   task t_fifo;
      n = 0;
      @(posedge sys_clk);
      dac_ready <= 1'b1; // flush a pattern sample left stalled
      @(posedge sys_clk);
      {vin_valid, vin_data, dac_ready} <= {1'b1, 10'h3FF, 1'b0};
      for (i = 0; i < 40; i++) begin
         @(negedge sys_clk);
         if (vin_ready !== 1'b1) break;
         n++;
         @(posedge sys_clk);
         vin_data <= 10'h3FF - 10'(n);
      end
      @(posedge sys_clk);
      {vin_valid, dac_ready} <= 2'b01;
      `CK("full", 1'b1, n >= 16 && n <= 17)
      j = 0;
      for (i = 0; i < 100 && j < n; i++) begin
         @(negedge sys_clk);
         if (dac_valid === 1'b1) begin
            `CK("dac", 10'h3FF - 10'(j), dac_data)
            j++;
         end
      end
      tmo(j < n);
   endtask
   // reset, then one scenario after another
   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, vin_valid, dac_ready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, vin_data} = '0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(negedge sys_clk);
      t_reset;
      t_cfg;
      t_axi;
      t_gen;
      t_store;
      t_fifo;
      results;
   end
endmodule
bind vesm_top vesm_chk #(.VID_W(VID_W)) i_vesm_chk (.sys_clk, .rst,
   .led_red, .led_green, .store_pulse, .sync_cfg, .dac_data, .dac_valid,
   .dac_ready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
